//--- pkg/mbs_pkg.sv
// Constants, codes and CRC helper shared by the Modbus status slave and its master
package mbs_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned BAUD          = 19200;
  localparam int unsigned BIT_CYC       = CLK_HZ / BAUD;
  localparam int unsigned BYTE_GAP_MS   = 20;
  localparam int unsigned BYTE_GAP_CYC  = BYTE_GAP_MS * (CLK_HZ / 1000);
  localparam int unsigned FRAME_GAP_MS  = 50;
  localparam int unsigned FRAME_GAP_CYC = FRAME_GAP_MS * (CLK_HZ / 1000);
  localparam int unsigned RESP_TO_MS    = 200;
  localparam int unsigned RESP_TO_CYC   = RESP_TO_MS * (CLK_HZ / 1000);
  // Serial character layout
  localparam logic [3:0]  UART_STOP_IDX = 4'h9;
  localparam logic [3:0]  UART_BITS     = 4'hA;
  // Protocol codes
  localparam logic [7:0]  FN_READ_HOLD  = 8'h03;
  localparam logic [7:0]  FN_EXC_FLAG   = 8'h80;
  localparam logic [7:0]  EXC_ILL_FUNC  = 8'h01;
  localparam logic [7:0]  EXC_ILL_ADDR  = 8'h02;
  localparam logic [7:0]  REQ_LEN       = 8'h08;
  localparam logic [7:0]  MIN_FRAME     = 8'h04;
  localparam logic [7:0]  MIN_REPLY     = 8'h05;
  localparam logic [7:0]  HDR_LEN       = 8'h03;
  localparam logic [7:0]  EXC_LEN       = 8'h05;
  localparam logic [15:0] CRC_INIT      = 16'hFFFF;
  localparam logic [15:0] CRC_POLY      = 16'hA001;
  // Holding register map
  localparam logic [15:0] REG_SEC_HI    = 16'h0004;
  localparam logic [15:0] REG_SEC_LO    = 16'h0005;
  localparam logic [15:0] REG_HEALTH    = 16'h0009;
  localparam logic [15:0] REG_SPEED     = 16'h000A;
  localparam logic [15:0] REG_DIR       = 16'h000B;
  localparam logic [15:0] REG_CURRENT   = 16'h000C;
  localparam logic [16:0] REG_END       = 17'h0000D;
  // Health and direction codes
  localparam logic [15:0] HLT_OK        = 16'h0000;
  localparam logic [15:0] HLT_JAM       = 16'h0001;
  localparam logic [15:0] HLT_GPS       = 16'h0100;
  localparam logic [15:0] HLT_MCOMM     = 16'h0003;
  localparam logic [15:0] HLT_HICUR     = 16'h0010;
  localparam logic [15:0] HLT_TEMP      = 16'h0030;
  localparam logic [15:0] HLT_RAIL      = 16'h0040;
  localparam logic [15:0] DIR_STOP      = 16'h0000;
  localparam logic [15:0] DIR_FWD       = 16'h0001;
  localparam logic [15:0] DIR_REV       = 16'h0003;
  // Master Wishbone register offsets
  localparam logic [7:0]  WB_CTRL       = 8'h00;
  localparam logic [7:0]  WB_RANGE      = 8'h04;
  localparam logic [7:0]  WB_STAT       = 8'h08;
  localparam logic [7:0]  WB_DATA       = 8'h10;
  localparam int unsigned DATA_WORDS    = 8;
  localparam int unsigned CTRL_GO_BIT   = 24;

  // One byte of the reflected CRC-16 used on the link
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

//--- pkg/mbs_if.sv
// Serial link between the Modbus master and the status slave
`timescale 1ns/1ps
interface mbs_if;
  logic m2s_txd;   // Master transmit, slave receive, idle high
  logic s2m_txd;   // Slave transmit, master receive, idle high
  modport slave (input m2s_txd, output s2m_txd);
  modport master (output m2s_txd, input s2m_txd);
endinterface

//--- verilog/mbs_slave.sv
// Modbus RTU status slave with its serial receiver
`timescale 1ns/1ps
module mbs_uart_rx #(
  parameter int unsigned BIT_CYC = mbs_pkg::BIT_CYC
) (
  // Clock and control
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // Serial in and received byte
  input  wire logic       rxd_i,
  output logic [7:0]      data_o,
  output logic            valid_o
);
  import mbs_pkg::*;
  logic [31:0] cnt_q;
  logic [3:0]  bit_q;
  logic [8:0]  sh_q;
  logic        busy_q;

  // Mid-bit sampling of start, eight data bits and stop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q   <= '0;
      bit_q   <= '0;
      sh_q    <= '0;
      busy_q  <= 1'b0;
      data_o  <= '0;
      valid_o <= 1'b0;
    end else if (ce_i) begin
      valid_o <= 1'b0;
      if (!busy_q) begin
        if (!rxd_i) begin
          busy_q <= 1'b1;
          cnt_q  <= 32'(BIT_CYC / 2);
          bit_q  <= '0;
        end
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 32'd1;
      end else begin
        cnt_q <= 32'(BIT_CYC - 1);
        if (bit_q == '0 && rxd_i) begin
          busy_q <= 1'b0;                  // False start
        end else if (bit_q == UART_STOP_IDX) begin
          busy_q <= 1'b0;
          if (rxd_i) begin
            data_o  <= sh_q[8:1];
            valid_o <= 1'b1;
          end
        end else begin
          sh_q  <= {rxd_i, sh_q[8:1]};
          bit_q <= bit_q + 4'h1;
        end
      end
    end
  end
endmodule

module mbs_slave #(
  parameter int unsigned BIT_CYC      = mbs_pkg::BIT_CYC,
  parameter int unsigned BYTE_GAP_CYC = mbs_pkg::BYTE_GAP_CYC
) (
  // Clock and control
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Factory slave address
  input  wire logic [7:0]  slave_id_i,
  // Status sources
  input  wire logic [31:0] seconds_i,
  input  wire logic        jam_recovery_i,
  input  wire logic        gps_acquiring_i,
  input  wire logic        motor_comm_err_i,
  input  wire logic        high_current_i,
  input  wire logic        temp_fault_i,
  input  wire logic        rail_fault_i,
  input  wire logic [15:0] speed_centi_rpm_i,
  input  wire logic        motor_run_i,
  input  wire logic        motor_reverse_i,
  input  wire logic [15:0] current_ma_i,
  // Serial link
  mbs_if.slave             link
);
  import mbs_pkg::*;
  typedef enum logic [2:0] {ST_RX = 3'b001, ST_EVAL = 3'b010, ST_TX = 3'b100} mbs_sstate_t;
  mbs_sstate_t st_q;
  logic [7:0]  buf_q [0:7];
  logic [7:0]  len_q;
  logic [15:0] crc_q;
  logic [31:0] gap_q;
  logic [31:0] sec_q;
  logic [7:0]  fn_q;
  logic [7:0]  exc_q;
  logic [15:0] start_q;
  logic [7:0]  nbytes_q;
  logic [7:0]  tx_len_q;
  logic [7:0]  idx_q;
  logic [15:0] tx_crc_q;
  logic [7:0]  rx_byte;
  logic        rx_vld;
  logic        tx_rdy;
  logic [7:0]  tx_byte;
  logic        tx_go;
  logic [15:0] health;
  logic [15:0] dir_code;
  logic [15:0] word;
  logic [7:0]  off;
  logic [16:0] req_end;
  logic        frame_good;

  mbs_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .rxd_i   (link.m2s_txd),
    .data_o  (rx_byte),
    .valid_o (rx_vld)
  );

  mbs_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .data_i  (tx_byte),
    .valid_i (tx_go),
    .ready_o (tx_rdy),
    .txd_o   (link.s2m_txd)
  );

  // Health code, faults taking priority over normal indications
  always_comb begin
    if (motor_comm_err_i)     health = HLT_MCOMM;
    else if (high_current_i)  health = HLT_HICUR;
    else if (temp_fault_i)    health = HLT_TEMP;
    else if (rail_fault_i)    health = HLT_RAIL;
    else if (jam_recovery_i)  health = HLT_JAM;
    else if (gps_acquiring_i) health = HLT_GPS;
    else                      health = HLT_OK;
    if (!motor_run_i)         dir_code = DIR_STOP;
    else if (motor_reverse_i) dir_code = DIR_REV;
    else                      dir_code = DIR_FWD;
  end

  // Register word for the byte being sent; zero-based map
  always_comb begin
    off = idx_q - HDR_LEN;
    case (start_q + {9'h000, off[7:1]})
      REG_SEC_HI:  word = sec_q[31:16];
      REG_SEC_LO:  word = sec_q[15:0];
      REG_HEALTH:  word = health;
      REG_SPEED:   word = speed_centi_rpm_i;
      REG_DIR:     word = dir_code;
      REG_CURRENT: word = current_ma_i;
      default:     word = 16'h0000;
    endcase
  end

  // Reply byte sequence: address, function, count or exception code, data, CRC
  always_comb begin
    if (idx_q == 8'h00)                tx_byte = slave_id_i;
    else if (idx_q == 8'h01)           tx_byte = (exc_q != '0) ? (fn_q | FN_EXC_FLAG) : fn_q;
    else if (idx_q == 8'h02)           tx_byte = (exc_q != '0) ? exc_q : nbytes_q;
    else if (idx_q == tx_len_q - 8'h2) tx_byte = tx_crc_q[7:0];
    else if (idx_q == tx_len_q - 8'h1) tx_byte = tx_crc_q[15:8];
    else                               tx_byte = off[0] ? word[7:0] : word[15:8];
  end
  assign tx_go = (st_q == ST_TX);

  // Frame check and requested range end
  assign frame_good = (crc_q == '0) && (len_q >= MIN_FRAME) && (buf_q[0] == slave_id_i);
  assign req_end    = {1'b0, buf_q[2], buf_q[3]} + {1'b0, buf_q[4], buf_q[5]};

  // Receive bytes, end frame on silence, decide, then send
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q     <= ST_RX;
      len_q    <= '0;
      crc_q    <= CRC_INIT;
      gap_q    <= '0;
      sec_q    <= '0;
      fn_q     <= '0;
      exc_q    <= '0;
      start_q  <= '0;
      nbytes_q <= '0;
      tx_len_q <= '0;
      idx_q    <= '0;
      tx_crc_q <= CRC_INIT;
      for (int i = 0; i < 8; i++) begin
        buf_q[i] <= '0;
      end
    end else if (ce_i) begin
      case (st_q)
        ST_RX: begin
          if (rx_vld) begin
            gap_q <= '0;
            crc_q <= crc_byte(crc_q, rx_byte);
            if (len_q < REQ_LEN) buf_q[len_q[2:0]] <= rx_byte;
            if (len_q != 8'hFF) len_q <= len_q + 8'h1;
          end else if (len_q != '0) begin
            if (gap_q >= 32'(BYTE_GAP_CYC)) st_q <= ST_EVAL;
            else gap_q <= gap_q + 32'd1;
          end
        end
        ST_EVAL: begin
          st_q     <= ST_RX;
          len_q    <= '0;
          crc_q    <= CRC_INIT;
          gap_q    <= '0;
          idx_q    <= '0;
          tx_crc_q <= CRC_INIT;
          fn_q     <= buf_q[1];
          start_q  <= {buf_q[2], buf_q[3]};
          nbytes_q <= {buf_q[5][6:0], 1'b0};
          sec_q    <= seconds_i;
          if (frame_good) begin
            if (buf_q[1] != FN_READ_HOLD) begin
              exc_q    <= EXC_ILL_FUNC;
              tx_len_q <= EXC_LEN;
              st_q     <= ST_TX;
            end else if (len_q == REQ_LEN) begin
              st_q <= ST_TX;
              if ({buf_q[4], buf_q[5]} == '0 || req_end > REG_END) begin
                exc_q    <= EXC_ILL_ADDR;
                tx_len_q <= EXC_LEN;
              end else begin
                exc_q    <= '0;
                tx_len_q <= HDR_LEN + {buf_q[5][6:0], 1'b0} + 8'h2;
              end
            end
          end
        end
        ST_TX: begin
          if (tx_rdy) begin
            // CRC bytes themselves must not fold into the sent CRC
            if (idx_q < tx_len_q - 8'h2) tx_crc_q <= crc_byte(tx_crc_q, tx_byte);
            idx_q    <= idx_q + 8'h1;
            if (idx_q == tx_len_q - 8'h1) st_q <= ST_RX;
          end
        end
        default: st_q <= ST_RX;
      endcase
    end
  end
endmodule

//--- verilog/mbs_master.sv
// Modbus RTU polling master with a Wishbone register port and the serial transmitter
`timescale 1ns/1ps
module mbs_uart_tx #(
  parameter int unsigned BIT_CYC = mbs_pkg::BIT_CYC
) (
  // Clock and control
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // Byte handshake and serial out
  input  wire logic [7:0] data_i,
  input  wire logic       valid_i,
  output logic            ready_o,
  output logic            txd_o
);
  import mbs_pkg::*;
  logic [31:0] cnt_q;
  logic [3:0]  bit_q;
  logic [9:0]  sh_q;

  // Ready when idle or in the last cycle of a stop bit, so bytes run back to back
  assign ready_o = (bit_q == '0) || (bit_q == 4'h1 && cnt_q == '0);
  assign txd_o   = sh_q[0];

  // Start bit, eight data bits LSB first, one stop bit, no parity
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      bit_q <= '0;
      sh_q  <= '1;
    end else if (ce_i) begin
      if (ready_o && valid_i) begin
        sh_q  <= {1'b1, data_i, 1'b0};
        bit_q <= UART_BITS;
        cnt_q <= 32'(BIT_CYC - 1);
      end else if (bit_q != '0 && cnt_q != '0) begin
        cnt_q <= cnt_q - 32'd1;
      end else if (bit_q != '0) begin
        sh_q  <= {1'b1, sh_q[9:1]};
        bit_q <= bit_q - 4'h1;
        cnt_q <= 32'(BIT_CYC - 1);
      end
    end
  end
endmodule

module mbs_master #(
  parameter int unsigned BIT_CYC       = mbs_pkg::BIT_CYC,
  parameter int unsigned BYTE_GAP_CYC  = mbs_pkg::BYTE_GAP_CYC,
  parameter int unsigned FRAME_GAP_CYC = mbs_pkg::FRAME_GAP_CYC,
  parameter int unsigned RESP_TO_CYC   = mbs_pkg::RESP_TO_CYC
) (
  // Clock and control
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Serial link
  mbs_if.master            link
);
  import mbs_pkg::*;
  typedef enum logic [3:0] {MS_IDLE = 4'b0001, MS_GAP = 4'b0010, MS_SEND = 4'b0100, MS_RECV = 4'b1000} mbs_mstate_t;
  mbs_mstate_t st_q;
  logic [31:0] ctrl_q;
  logic [31:0] range_q;
  logic [15:0] data_q [0:DATA_WORDS-1];
  logic        done_q;
  logic        bad_q;
  logic        tmo_q;
  logic        exc_q;
  logic [7:0]  code_q;
  logic [7:0]  len_q;
  logic [7:0]  b0_q;
  logic [7:0]  b1_q;
  logic [15:0] crc_q;
  logic [31:0] quiet_q;
  logic [31:0] wait_q;
  logic [2:0]  idx_q;
  logic [7:0]  tx_byte;
  logic [7:0]  rx_byte;
  logic        rx_vld;
  logic        tx_rdy;
  logic        wr;
  logic [7:0]  doff;

  mbs_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .rxd_i   (link.s2m_txd),
    .data_o  (rx_byte),
    .valid_o (rx_vld)
  );

  mbs_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .data_i  (tx_byte),
    .valid_i (st_q == MS_SEND),
    .ready_o (tx_rdy),
    .txd_o   (link.m2s_txd)
  );

  // Request bytes: address, function, start, count, CRC
  always_comb begin
    case (idx_q)
      3'h0:    tx_byte = ctrl_q[7:0];
      3'h1:    tx_byte = ctrl_q[15:8];
      3'h2:    tx_byte = range_q[15:8];
      3'h3:    tx_byte = range_q[7:0];
      3'h4:    tx_byte = range_q[31:24];
      3'h5:    tx_byte = range_q[23:16];
      3'h6:    tx_byte = crc_q[7:0];
      default: tx_byte = crc_q[15:8];
    endcase
  end

  // Write strobe at the acknowledged edge; data window offset
  assign wr   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign doff = wb_adr_i - WB_DATA;

  // Bus answer one cycle after request, read data registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_adr_i == WB_CTRL)       wb_dat_o <= {8'h00, ctrl_q[23:0]};
      else if (wb_adr_i == WB_RANGE) wb_dat_o <= range_q;
      else if (wb_adr_i == WB_STAT)  wb_dat_o <= {16'h0000, code_q, 3'h0, exc_q, tmo_q, bad_q, done_q, st_q != MS_IDLE};
      else if (wb_adr_i >= WB_DATA && doff < 8'(DATA_WORDS * 4) && doff[1:0] == 2'h0)
        wb_dat_o <= {16'h0000, data_q[doff[4:2]]};
      else                           wb_dat_o <= '0;
    end
  end

  // Control and range registers with byte enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q  <= {16'h0000, FN_READ_HOLD, 8'h01};
      range_q <= '0;
    end else if (ce_i) begin
      ctrl_q[CTRL_GO_BIT] <= 1'b0;
      for (int b = 0; b < 4; b++) begin
        if (wr && wb_sel_i[b] && wb_adr_i == WB_CTRL)  ctrl_q[8*b +: 8]  <= wb_dat_i[8*b +: 8];
        if (wr && wb_sel_i[b] && wb_adr_i == WB_RANGE) range_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
      end
    end
  end

  // Link quiet time since the last request left the line
  always_ff @(posedge clk_i) begin
    if (rst_i) quiet_q <= '0;
    else if (ce_i) begin
      if (st_q == MS_SEND || !tx_rdy) quiet_q <= '0;
      else if (quiet_q < 32'(FRAME_GAP_CYC)) quiet_q <= quiet_q + 32'd1;
    end
  end

  // Poll sequence: gap, send request, collect reply, report
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q   <= MS_IDLE;
      done_q <= 1'b0;
      bad_q  <= 1'b0;
      tmo_q  <= 1'b0;
      exc_q  <= 1'b0;
      code_q <= '0;
      len_q  <= '0;
      b0_q   <= '0;
      b1_q   <= '0;
      crc_q  <= CRC_INIT;
      wait_q <= '0;
      idx_q  <= '0;
      for (int i = 0; i < DATA_WORDS; i++) begin
        data_q[i] <= '0;
      end
    end else if (ce_i) begin
      case (st_q)
        MS_IDLE: begin
          if (ctrl_q[CTRL_GO_BIT]) begin
            st_q   <= MS_GAP;
            done_q <= 1'b0;
            crc_q  <= CRC_INIT;
            idx_q  <= '0;
          end
        end
        MS_GAP: begin
          if (quiet_q >= 32'(FRAME_GAP_CYC)) st_q <= MS_SEND;
        end
        MS_SEND: begin
          if (tx_rdy) begin
            // CRC covers the six header bytes only
            if (idx_q < 3'h6) crc_q <= crc_byte(crc_q, tx_byte);
            idx_q <= idx_q + 3'h1;
            if (idx_q == 3'h7) begin
              st_q   <= MS_RECV;
              len_q  <= '0;
              wait_q <= '0;
              crc_q  <= CRC_INIT;
            end
          end
        end
        MS_RECV: begin
          if (rx_vld) begin
            wait_q <= '0;
            crc_q  <= crc_byte(crc_q, rx_byte);
            if (len_q != 8'hFF) len_q <= len_q + 8'h1;
            if (len_q == 8'h0) b0_q <= rx_byte;
            if (len_q == 8'h1) b1_q <= rx_byte;
            if (len_q == 8'h2) code_q <= rx_byte;
            if (len_q >= HDR_LEN && len_q < HDR_LEN + 8'(DATA_WORDS * 2)) begin
              if (len_q[0]) data_q[3'((len_q - HDR_LEN) >> 1)][15:8] <= rx_byte;
              else data_q[3'((len_q - HDR_LEN) >> 1)][7:0] <= rx_byte;
            end
          end else if (len_q == '0 && wait_q >= 32'(RESP_TO_CYC)) begin
            st_q   <= MS_IDLE;
            done_q <= 1'b1;
            tmo_q  <= 1'b1;
            bad_q  <= 1'b0;
            exc_q  <= 1'b0;
          end else if (len_q != '0 && wait_q >= 32'(BYTE_GAP_CYC)) begin
            st_q   <= MS_IDLE;
            done_q <= 1'b1;
            tmo_q  <= 1'b0;
            bad_q  <= crc_q != '0 || len_q < MIN_REPLY || b0_q != ctrl_q[7:0];
            exc_q  <= b1_q == (ctrl_q[15:8] | FN_EXC_FLAG);
          end else begin
            wait_q <= wait_q + 32'd1;
          end
        end
        default: st_q <= MS_IDLE;
      endcase
    end
  end
endmodule

//--- verif/mbs_link_properties.sv
// Timing checks on the serial link between the two ends
`timescale 1ns/1ps
module mbs_link_properties #(
  parameter int unsigned BIT_CYC       = 16,
  parameter int unsigned BYTE_GAP_CYC  = 400,
  parameter int unsigned FRAME_GAP_CYC = 800
) (
  // Clock, reset and link lines
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic m2s_txd,
  input  wire logic s2m_txd
);
  logic        m_prev_q, s_prev_q;
  logic [31:0] m_run_q, s_run_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Length of the present level run on each line
  always_ff @(posedge clk_i) begin
    m_prev_q <= rst_i ? 1'b1 : m2s_txd;
    s_prev_q <= rst_i ? 1'b1 : s2m_txd;
    m_run_q  <= rst_i ? 32'h0 : ((m2s_txd != m_prev_q) ? 32'h1 : m_run_q + 32'h1);
    s_run_q  <= rst_i ? 32'h0 : ((s2m_txd != s_prev_q) ? 32'h1 : s_run_q + 32'h1);
  end
  a_m2s_low_len: assert property ($rose(m2s_txd) |-> m_run_q % BIT_CYC == 0 && m_run_q <= 9 * BIT_CYC)
    else $error("master low run off");
  a_s2m_low_len: assert property ($rose(s2m_txd) |-> s_run_q % BIT_CYC == 0 && s_run_q <= 9 * BIT_CYC)
    else $error("slave low run off");
  a_m2s_high_len: assert property ($fell(m2s_txd) && m_run_q < BYTE_GAP_CYC |-> m_run_q % BIT_CYC == 0)
    else $error("master high run off");
  a_s2m_high_len: assert property ($fell(s2m_txd) && s_run_q < BYTE_GAP_CYC |-> s_run_q % BIT_CYC == 0)
    else $error("slave high run off");
  a_reply_after_gap: assert property ($fell(s2m_txd) |-> m_run_q >= BYTE_GAP_CYC)
    else $error("reply before frame end");
  a_request_spacing: assert property ($fell(m2s_txd) && m_run_q >= BYTE_GAP_CYC |-> m_run_q >= FRAME_GAP_CYC - 2)
    else $error("request too soon");
  a_no_overlap: assert property (m2s_txd || s2m_txd)
    else $error("frames overlap");
  a_idle_after_reset: assert property ($fell(rst_i) |-> m2s_txd && s2m_txd)
    else $error("line not idle after reset");
endmodule

//--- verif/test_modbus_status_register_slave.sv
// Bench: the master polls the status slave over the serial link
`timescale 1ns/1ps
module test_modbus_status_register_slave;
  import mbs_pkg::*;
  localparam int unsigned BC = 16, BG = 400, FG = 800, RT = 4000;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, run = 1'b0, rev = 1'b0;
  logic [7:0]  adr = 8'h00, sid = 8'h11;
  logic [5:0]  flg = 6'h00;
  logic [15:0] spd = 16'h1F40, cur = 16'h0BB8;
  logic [31:0] wdat = 32'h0, rdat, sec = 32'hA5C3_1E0F;
  int          fails = 0, num_checks = 0, cycles = 0;
  mbs_if u_mbs_if ();
  mbs_slave #(.BIT_CYC(BC), .BYTE_GAP_CYC(BG)) u_mbs_slave (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .slave_id_i(sid), .seconds_i(sec), .jam_recovery_i(flg[1]), .gps_acquiring_i(flg[0]),
    .motor_comm_err_i(flg[5]), .high_current_i(flg[4]), .temp_fault_i(flg[3]), .rail_fault_i(flg[2]),
    .speed_centi_rpm_i(spd), .motor_run_i(run), .motor_reverse_i(rev), .current_ma_i(cur), .link(u_mbs_if.slave));
  mbs_master #(.BIT_CYC(BC), .BYTE_GAP_CYC(BG), .FRAME_GAP_CYC(FG), .RESP_TO_CYC(RT)) u_mbs_master (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .link(u_mbs_if.master));
  mbs_link_properties #(.BIT_CYC(BC), .BYTE_GAP_CYC(BG), .FRAME_GAP_CYC(FG)) u_mbs_link_properties (
    .clk_i(clk_i), .rst_i(rst_i), .m2s_txd(u_mbs_if.m2s_txd), .s2m_txd(u_mbs_if.s2m_txd));
  // Clock and hang limit
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 100000) begin
      fails++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) chk("ack", 32'h1, 32'h0);
  endtask
  // Issue one request and wait for its outcome
  task automatic poll(input logic [7:0] id, fn, input logic [15:0] st, cnt, output logic [31:0] s);
    int n;
    n = 0;
    wb(1'b1, WB_RANGE, {cnt, st}, s);
    wb(1'b1, WB_CTRL, {8'h01, 8'h00, fn, id}, s);
    do begin
      wb(1'b0, WB_STAT, 32'h0, s);
      n++;
    end while ((s[0] || s[4:1] == 4'h0) && n < 5000);
  endtask
  task automatic words(input int n, input logic [15:0] e [8]);
    logic [31:0] s;
    for (int k = 0; k < n; k++) begin
      wb(1'b0, WB_DATA + 8'(4 * k), 32'h0, s);
      chk("data word", {16'h0, e[k]}, s);
    end
  endtask
  task automatic t_map();
    logic [31:0] s;
    run <= 1'b1;
    rev <= 1'b1;
    poll(sid, FN_READ_HOLD, 16'd5, 16'd8, s);
    chk("map status", 32'h1002, {s[15:8], 3'h0, s[4:0]});
    words(8, '{sec[15:0], 16'h0, 16'h0, 16'h0, HLT_OK, spd, DIR_REV, cur});
    poll(sid, FN_READ_HOLD, 16'd0, 16'd5, s);
    chk("low status", 32'h0A02, {s[15:8], 3'h0, s[4:0]});
    words(5, '{16'h0, 16'h0, 16'h0, 16'h0, sec[31:16], 16'h0, 16'h0, 16'h0});
    wb(1'b0, 8'h40, 32'h0, s);
    chk("unmapped", 32'h0, s);
  endtask
  task automatic t_health();
    logic [31:0] s;
    logic [5:0]  f [7] = '{6'h00, 6'h02, 6'h01, 6'h21, 6'h12, 6'h09, 6'h04};
    logic [15:0] h [7] = '{HLT_OK, HLT_JAM, HLT_GPS, HLT_MCOMM, HLT_HICUR, HLT_TEMP, HLT_RAIL};
    logic [15:0] d [3] = '{DIR_STOP, DIR_FWD, DIR_REV};
    for (int i = 0; i < 7; i++) begin
      flg <= f[i];
      run <= (i % 3 != 0);
      rev <= (i % 3 == 2);
      spd <= 16'h0100 + 16'(i);
      poll(sid, FN_READ_HOLD, 16'd9, 16'd3, s);
      words(3, '{h[i], 16'h0100 + 16'(i), d[i % 3], 16'h0, 16'h0, 16'h0, 16'h0, 16'h0});
    end
  endtask
  task automatic t_exc();
    logic [31:0] s;
    logic [7:0]  fn [3] = '{8'h04, FN_READ_HOLD, FN_READ_HOLD};
    logic [15:0] st [3] = '{16'd0, 16'd12, 16'd0};
    logic [15:0] cn [3] = '{16'd1, 16'd2, 16'd0};
    logic [7:0]  cd [3] = '{EXC_ILL_FUNC, EXC_ILL_ADDR, EXC_ILL_ADDR};
    for (int i = 0; i < 3; i++) begin
      poll(sid, fn[i], st[i], cn[i], s);
      chk("exception", {23'h0, cd[i], 1'b1}, {23'h0, s[15:8], s[4]});
    end
  endtask
  task automatic t_addr();
    logic [31:0] s;
    poll(sid + 8'h01, FN_READ_HOLD, 16'd5, 16'd1, s);
    chk("foreign timeout", 32'h1, {31'h0, s[3]});
    sid <= 8'h5A;
    sec <= 32'h0001_2345;
    poll(8'h5A, FN_READ_HOLD, 16'd4, 16'd2, s);
    chk("new id status", 32'h0402, {s[15:8], 3'h0, s[4:0]});
    words(2, '{16'h0001, 16'h2345, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0});
    sec <= 32'h0001_2346;
    poll(8'h5A, FN_READ_HOLD, REG_SEC_LO, 16'd1, s);
    words(1, '{16'h2346, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0});
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_map();
    t_health();
    t_exc();
    t_addr();
    close_out();
  end
endmodule
